// File: rtl/flash_ctrl_defs.svh
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FC_OFF_CTRL       2'h0
`define FC_OFF_PROT       2'h1
`define FC_OFF_STAT       2'h2

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FC_CTRL_PGM       0
`define FC_CTRL_ERASE     1
`define FC_CTRL_MASS      2
`define FC_CTRL_HV        3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define FC_STAT_BLOCKED   0
`define FC_STAT_STANDBY   1
`define FC_STAT_PROTRD    2
`define FC_STAT_HVON      3

// ----------------------------------------------------------------
// Flash map and protect encoding
// ----------------------------------------------------------------
`define FC_FLASH_LO       16'hc000
`define FC_PROT_ADDR      16'hff7e
`define FC_START_TOP      2'h3
`define FC_START_LOW      6'h00
`define FC_PAGE_MASK      16'hffc0
`define FC_ROW_MASK       16'hffe0
`define FC_PROT_OPEN      8'hff
`define FC_PROT_VEC       8'hfe
`define FC_ERASED         8'hff
`define FC_BYTE_ZERO      8'h00

`endif

// File: rtl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

    // ----------------------------------------------------------------
    // Sequence states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        seq_idle,
        seq_selected,
        seq_prot_read,
        seq_latched,
        seq_hv
    } seq_e;

    // ----------------------------------------------------------------
    // CPU store into the flash address space
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_store_s;

    // ----------------------------------------------------------------
    // Controls towards the flash array
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        program_select;
        logic        erase_select;
        logic        mass;
        logic        high_voltage_enable;
        logic        byte_wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } array_ctl_s;

    // ----------------------------------------------------------------
    // Whole state of the controller
    // ----------------------------------------------------------------
    typedef struct packed {
        seq_e        seq;
        logic        blocked;
        logic        standby;
        logic [15:0] target;
        logic [7:0]  protect_start_bits;
        logic        tst_meta;
        logic        tst_sync;
        logic [7:0]  rdata;
        array_ctl_s  arr;
    } ctrl_state_s;

endpackage : flash_ctrl_pkg

// File: rtl/flash_program_protect_ctrl.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`include "flash_ctrl_defs.svh"

module flash_program_protect_ctrl #(
    parameter logic [7:0] PROTECT_INIT = `FC_PROT_OPEN
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        srst,
    // Register port
    input  wire logic [1:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [7:0]                  reg_rdata,
    // CPU stores into flash space
    input  wire flash_ctrl_pkg::flash_store_s flash_store,
    // Low-power entry pulses from the core
    input  wire logic                        wait_entry,
    input  wire logic                        stop_entry,
    // Test high-voltage detector on the interrupt pin
    input  wire logic                        test_high_voltage,
    // Array side
    output flash_ctrl_pkg::array_ctl_s       array_ctl,
    output logic      [7:0]                  protect_start_byte,
    output logic                             flash_standby
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // start address forming
    function automatic logic [15:0] prot_start(input logic [7:0] bits);
        prot_start = {`FC_START_TOP, bits, `FC_START_LOW};
    endfunction : prot_start

    function automatic logic addr_locked(input logic [15:0] addr,
                                         input logic [7:0]  bits,
                                         input logic        bypass);
        logic open_all;
        logic byte_lock;
        open_all  = (bits == `FC_PROT_OPEN);
        byte_lock = (bits != `FC_PROT_OPEN) && (bits != `FC_PROT_VEC);
        if (bypass) begin
            addr_locked = 1'b0;
        end else if (open_all) begin
            addr_locked = 1'b0;
        end else if (byte_lock && addr == `FC_PROT_ADDR) begin
            addr_locked = 1'b1;
        end else begin
            // ff40 and ff80 fall out here
            addr_locked = (addr >= prot_start(bits));
        end
    endfunction : addr_locked

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    flash_ctrl_pkg::ctrl_state_s st_reg;
    flash_ctrl_pkg::ctrl_state_s st_next;

    logic bypass;
    logic ctrl_wr;
    logic prot_rd;
    logic busy;
    logic want_pgm;
    logic want_erase;
    logic want_hv;
    logic mass_lock;

    assign bypass   = st_reg.tst_sync;
    assign ctrl_wr  = reg_wr && reg_addr == `FC_OFF_CTRL;
    assign prot_rd  = reg_rd && reg_addr == `FC_OFF_PROT;
    assign busy     = st_reg.arr.program_select || st_reg.arr.erase_select
                      || st_reg.arr.high_voltage_enable;
    assign want_pgm   = reg_wdata[`FC_CTRL_PGM];
    assign want_erase = reg_wdata[`FC_CTRL_ERASE];
    assign want_hv    = reg_wdata[`FC_CTRL_HV];
    assign mass_lock  = !bypass && st_reg.protect_start_bits != `FC_PROT_OPEN;

    always_comb begin
        st_next = st_reg;
        st_next.arr.byte_wr = 1'b0;
        st_next.rdata = `FC_BYTE_ZERO;

        // Pin crosses two flops before use
        st_next.tst_meta = test_high_voltage;
        st_next.tst_sync = st_reg.tst_meta;

        // ------------------------------------------------------------
        // Control register writes
        // ------------------------------------------------------------
        if (ctrl_wr) begin
            st_next.standby = 1'b0;
            if (!(want_pgm && want_erase)) begin
                st_next.arr.program_select = want_pgm && !st_reg.arr.erase_select;
                st_next.arr.erase_select   = want_erase && !st_reg.arr.program_select;
            end
            st_next.arr.mass = reg_wdata[`FC_CTRL_MASS];
            if (!want_hv) begin
                st_next.arr.high_voltage_enable = 1'b0;
            end else if (!st_reg.arr.high_voltage_enable
                         && st_reg.seq == flash_ctrl_pkg::seq_latched
                         && (st_reg.arr.program_select || st_reg.arr.erase_select)
                         && !st_reg.blocked) begin
                st_next.arr.high_voltage_enable = 1'b1;
                st_next.seq = flash_ctrl_pkg::seq_hv;
                if (st_reg.arr.erase_select
                    && (st_reg.arr.mass
                        || (st_reg.target & `FC_PAGE_MASK)
                           == (`FC_PROT_ADDR & `FC_PAGE_MASK))) begin
                    st_next.protect_start_bits = `FC_ERASED;
                end
            end
            // Sequence restarts on a fresh select
            if (st_reg.seq != flash_ctrl_pkg::seq_hv
                && st_next.seq != flash_ctrl_pkg::seq_hv) begin
                if (st_next.arr.program_select || st_next.arr.erase_select) begin
                    if (st_reg.seq == flash_ctrl_pkg::seq_idle) begin
                        st_next.seq = flash_ctrl_pkg::seq_selected;
                    end
                end else begin
                    st_next.seq = flash_ctrl_pkg::seq_idle;
                end
            end else if (!st_next.arr.high_voltage_enable) begin
                st_next.seq = flash_ctrl_pkg::seq_idle;
            end
        end

        // ------------------------------------------------------------
        // Protect byte read step
        // ------------------------------------------------------------
        // read step recorded
        if (prot_rd && st_reg.seq == flash_ctrl_pkg::seq_selected) begin
            st_next.seq = flash_ctrl_pkg::seq_prot_read;
        end

        // ------------------------------------------------------------
        // Stores into flash space
        // ------------------------------------------------------------
        if (flash_store.wr && flash_store.addr >= `FC_FLASH_LO && !ctrl_wr) begin
            if (st_reg.seq == flash_ctrl_pkg::seq_prot_read
                || st_reg.seq == flash_ctrl_pkg::seq_latched) begin
                st_next.target = flash_store.addr;
                st_next.seq    = flash_ctrl_pkg::seq_latched;
                if (st_reg.arr.erase_select && st_reg.arr.mass) begin
                    st_next.blocked = mass_lock;
                end else begin
                    st_next.blocked = addr_locked(flash_store.addr,
                                                  st_reg.protect_start_bits, bypass);
                end
            end else if (st_reg.seq == flash_ctrl_pkg::seq_hv
                         && st_reg.arr.program_select
                         && (flash_store.addr & `FC_ROW_MASK)
                            == (st_reg.target & `FC_ROW_MASK)
                         && !addr_locked(flash_store.addr,
                                         st_reg.protect_start_bits, bypass)) begin
                st_next.arr.byte_wr = 1'b1;
                st_next.arr.addr    = flash_store.addr;
                st_next.arr.data    = flash_store.data;
                // Programming only clears bits
                if (flash_store.addr == `FC_PROT_ADDR) begin
                    st_next.protect_start_bits = st_reg.protect_start_bits
                                                 & flash_store.data;
                end
            end
        end

        // ------------------------------------------------------------
        // Low-power entry abort
        // ------------------------------------------------------------
        // wait or stop entry aborts
        if ((wait_entry || stop_entry) && busy) begin
            st_next.arr     = '0;
            st_next.standby = 1'b1;
            st_next.seq     = flash_ctrl_pkg::seq_idle;
            st_next.blocked = 1'b0;
        end

        // ------------------------------------------------------------
        // Register reads, data in the following cycle
        // ------------------------------------------------------------
        if (reg_rd) begin
            unique case (reg_addr)
                `FC_OFF_CTRL: begin
                    st_next.rdata[`FC_CTRL_PGM]   = st_reg.arr.program_select;
                    st_next.rdata[`FC_CTRL_ERASE] = st_reg.arr.erase_select;
                    st_next.rdata[`FC_CTRL_MASS]  = st_reg.arr.mass;
                    st_next.rdata[`FC_CTRL_HV]    = st_reg.arr.high_voltage_enable;
                end
                `FC_OFF_PROT: begin
                    st_next.rdata = st_reg.protect_start_bits;
                end
                `FC_OFF_STAT: begin
                    st_next.rdata[`FC_STAT_BLOCKED] = st_reg.blocked;
                    st_next.rdata[`FC_STAT_STANDBY] = st_reg.standby;
                    st_next.rdata[`FC_STAT_PROTRD]  =
                        st_reg.seq == flash_ctrl_pkg::seq_prot_read
                        || st_reg.seq == flash_ctrl_pkg::seq_latched
                        || st_reg.seq == flash_ctrl_pkg::seq_hv;
                    st_next.rdata[`FC_STAT_HVON]    = st_reg.seq == flash_ctrl_pkg::seq_hv;
                end
                default: begin
                    st_next.rdata = `FC_BYTE_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg                    <= '0;
            st_reg.seq                <= flash_ctrl_pkg::seq_idle;
            // Nonvolatile byte: reset loads PROTECT_INIT, not the value last programmed
            st_reg.protect_start_bits <= PROTECT_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata          = st_reg.rdata;
    assign array_ctl          = st_reg.arr;
    assign protect_start_byte = st_reg.protect_start_bits;
    assign flash_standby      = st_reg.standby;

endmodule : flash_program_protect_ctrl

// File: tb/flash_ctrl_chk.sv
module flash_ctrl_chk (
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       srst,
    // Observed ports
    input wire logic                       reg_rd,
    input wire logic [7:0]                 reg_rdata,
    input wire logic                       wait_entry,
    input wire logic                       stop_entry,
    input wire logic                       test_high_voltage,
    input wire flash_ctrl_pkg::array_ctl_s array_ctl,
    input wire logic [7:0]                 protect_start_byte,
    input wire logic                       flash_standby
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    logic sel;
    logic hv;
    assign sel = array_ctl.program_select | array_ctl.erase_select;
    assign hv  = array_ctl.high_voltage_enable;

    // ----------------------------------------------------------------
    // Sequence and protection
    // ----------------------------------------------------------------
    sel_interlock_a: assert property (!(array_ctl.program_select && array_ctl.erase_select))
        else $error("program and erase select high together");
    hv_needs_sel_a: assert property ($rose(hv) |-> sel)
        else $error("high voltage rose without a select");
    // Bench holds the test pin steady around each operation, so no sync delay here
    hv_all_prot_a: assert property ($rose(hv) |-> $past(protect_start_byte) != 8'h00 || test_high_voltage)
        else $error("high voltage with everything protected");
    mass_lock_a: assert property ($rose(hv) && array_ctl.mass |-> $past(protect_start_byte) == 8'hff || test_high_voltage)
        else $error("mass erase while a block is protected");
    byte_range_a: assert property (array_ctl.byte_wr |-> $past(protect_start_byte) == 8'hff || test_high_voltage
        || array_ctl.addr < {2'h3, $past(protect_start_byte), 6'h00})
        else $error("byte written inside protected range");
    byte_hv_a: assert property (array_ctl.byte_wr |-> hv && array_ctl.program_select)
        else $error("byte written outside a program sequence");

    // ----------------------------------------------------------------
    // Low power and register port
    // ----------------------------------------------------------------
    abort_idle_a: assert property ((wait_entry || stop_entry) && (sel || hv) |=> flash_standby && !sel && !hv)
        else $error("low power entry did not abort");
    standby_quiet_a: assert property (flash_standby |-> !(sel || hv || array_ctl.mass || array_ctl.byte_wr))
        else $error("array control active in standby");
    rdata_gap_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : flash_ctrl_chk

bind flash_program_protect_ctrl flash_ctrl_chk flash_ctrl_chk_i (.core_clk(core_clk), .srst(srst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_entry(wait_entry), .stop_entry(stop_entry),
    .test_high_voltage(test_high_voltage), .array_ctl(array_ctl),
    .protect_start_byte(protect_start_byte), .flash_standby(flash_standby));

// File: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         core_clk;
    logic                         srst;
    logic [1:0]                   reg_addr;
    logic [7:0]                   reg_wdata;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_rdata;
    flash_ctrl_pkg::flash_store_s flash_store;
    logic                         wait_entry;
    logic                         stop_entry;
    logic                         test_high_voltage;
    flash_ctrl_pkg::array_ctl_s   array_ctl;
    logic [7:0]                   protect_start_byte;
    logic                         flash_standby;
    logic [7:0]                   d;
    int                           err_count;
    int                           checks_done;
    int                           cycles;

    flash_program_protect_ctrl flash_program_protect_ctrl_i (.core_clk(core_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_store(flash_store), .wait_entry(wait_entry),
        .stop_entry(stop_entry), .test_high_voltage(test_high_voltage), .array_ctl(array_ctl),
        .protect_start_byte(protect_start_byte), .flash_standby(flash_standby));

    always #10 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task give_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Generous ceiling; the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            give_verdict;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        #1;
    endtask : wr

    task rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        v = reg_rdata;
    endtask : rd

    task store(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        flash_store <= '{wr: 1'h1, addr: a, data: v};
        @(posedge core_clk);
        flash_store.wr <= 1'h0;
        #1;
    endtask : store

    task do_reset;
        @(posedge core_clk);
        srst <= 1'h1;
        repeat (2) @(posedge core_clk);
        srst <= 1'h0;
        #1;
    endtask : do_reset

    task start_op(input logic [7:0] c, input logic [15:0] a, input logic ok);
        wr(2'h0, c);
        rd(2'h1, d);
        store(a, 8'h00);
        // Latched target: protect read done, blocked when refused
        rd(2'h2, d);
        chk(d, {7'h02, !ok});
        wr(2'h0, c | 8'h08);
        chk(array_ctl.high_voltage_enable, ok);
    endtask : start_op

    task end_op;
        wr(2'h0, 8'h08);
        wr(2'h0, 8'h00);
    endtask : end_op

    task prog(input logic [15:0] a, input logic [7:0] v, input logic ok);
        start_op(8'h01, a, ok);
        store(a, v);
        chk(array_ctl.byte_wr, ok);
        if (ok) begin
            chk({array_ctl.addr, array_ctl.data}, {a, v});
        end
        end_op;
    endtask : prog

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset_regs;
        chk(array_ctl[28:24], 5'h00);
        rd(2'h1, d);
        chk(d, 8'hff);
        rd(2'h3, d);
        chk(d, 8'h00);
        wr(2'h1, 8'h00);
        rd(2'h1, d);
        chk(d, 8'hff);
    endtask : t_reset_regs

    task t_interlock;
        wr(2'h0, 8'h03);
        chk(array_ctl[28:27], 2'h0);
        wr(2'h0, 8'h08);
        chk(array_ctl.high_voltage_enable, 1'h0);
        wr(2'h0, 8'h01);
        wr(2'h0, 8'h02);
        chk(array_ctl[28:27], 2'h0);
        wr(2'h0, 8'h00);
    endtask : t_interlock

    task t_open;
        prog(16'hc000, 8'h5a, 1'h1);
        start_op(8'h06, 16'hc000, 1'h1);
        chk(array_ctl.mass, 1'h1);
        end_op;
    endtask : t_open

    task t_start_ff40;
        do_reset;
        prog(16'hff7e, 8'hfd, 1'h1);
        chk(protect_start_byte, 8'hfd);
        prog(16'hff40, 8'h00, 1'h0);
        prog(16'hff20, 8'h11, 1'h1);
        prog(16'hff7e, 8'h00, 1'h0);
        start_op(8'h06, 16'hc000, 1'h0);
        end_op;
    endtask : t_start_ff40

    task t_start_ff80;
        do_reset;
        prog(16'hff7e, 8'hfe, 1'h1);
        prog(16'hff80, 8'h00, 1'h0);
        prog(16'hff60, 8'h22, 1'h1);
        start_op(8'h02, 16'hff40, 1'h1);
        end_op;
        chk(protect_start_byte, 8'hff);
    endtask : t_start_ff80

    task t_all_locked;
        do_reset;
        prog(16'hff7e, 8'h00, 1'h1);
        prog(16'hc000, 8'h00, 1'h0);
        test_high_voltage <= 1'h1;
        repeat (4) @(posedge core_clk);
        prog(16'hc000, 8'h33, 1'h1);
        test_high_voltage <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask : t_all_locked

    task t_abort;
        do_reset;
        start_op(8'h01, 16'hc000, 1'h1);
        @(posedge core_clk);
        wait_entry <= 1'h1;
        @(posedge core_clk);
        wait_entry <= 1'h0;
        #1;
        chk({flash_standby, array_ctl[28:24]}, 6'h20);
        rd(2'h2, d);
        chk(d[1], 1'h1);
        start_op(8'h02, 16'hc000, 1'h1);
        @(posedge core_clk);
        stop_entry <= 1'h1;
        @(posedge core_clk);
        stop_entry <= 1'h0;
        #1;
        chk({flash_standby, array_ctl[28:24]}, 6'h20);
        wr(2'h0, 8'h00);
        chk(flash_standby, 1'h0);
    endtask : t_abort

    initial begin
        core_clk          = 1'h0;
        srst              = 1'h1;
        reg_addr          = 2'h0;
        reg_wdata         = 8'h00;
        reg_wr            = 1'h0;
        reg_rd            = 1'h0;
        flash_store       = '0;
        wait_entry        = 1'h0;
        stop_entry        = 1'h0;
        test_high_voltage = 1'h0;
        err_count         = 0;
        checks_done       = 0;
        cycles            = 0;
        repeat (2) @(posedge core_clk);
        srst <= 1'h0;
        #1;
        t_reset_regs;
        t_interlock;
        t_open;
        t_start_ff40;
        t_start_ff80;
        t_all_locked;
        t_abort;
        give_verdict;
    end
endmodule : tb_top
